// File: logic/reload_updown_timer_clockout.sv
/*
 * Sixteen-bit reload/capture timer with up/down counting, baud-clock source
 * and 50% clock output, reached through byte-wide special-function registers.
 * Assumes a single-cycle register port on clk_sys and asynchronous pins.
 */
// Notes on behaviour
// - Count is two cascaded bytes, sixteen bits.
// - Control bit 1 picks internal clock or pin.
// - Low byte counts only while run bit set.
// - Up/down enable: direction pin selects direction.
// - Up overflow past FFFFh: flag, irq, reload (capture loads zero).
// - Down: count equals reload gives underflow, loads FFFFh.
// - Up/down wraps toggle ext flag; that toggle gives no irq.
// - Clock-out: reload on overflow, 50% clock, no irq.
// - Clock out on count pin, rate over 4(65536-reload).
// - Baud and clock-out share one reload value.
// - Overflow flag set unless serial select or clock-out set.
// - Bit 6 set by enabled falling edge event.
// - Bit 5 picks this timer as receive clock.
// - Bit 3 enables direction pin edge action.
// - Control register resets zero, bit addressable.
// - Mode register: clock-out bit 1, up/down bit 0.
`timescale 1ns/1ns
`default_nettype none

`include "reload_timer_cfg.svh"

module reload_updown_timer_clockout (
	// Clock and reset.
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	// Special-function register port.
	input  wire logic [7:0]                  sfr_addr,
	input  wire logic                        sfr_wr,
	input  wire logic                        sfr_rd,
	input  wire reload_timer_pkg::sfr_byte_t sfr_wdata,
	input  wire logic                        sfr_bit_wr,
	input  wire logic [2:0]                  sfr_bit_sel,
	input  wire logic                        sfr_bit_val,
	output logic                             sfr_rdata_valid,
	output reload_timer_pkg::sfr_byte_t      sfr_rdata,
	// Pins.
	input  wire logic                        count_pin_i,
	output logic                             count_pin_o,
	output logic                             count_pin_oe_n,
	input  wire logic                        direction_pin,
	// Interrupt and serial clocks.
	output logic                             timer_irq,
	output logic                             serial_rx_tick,
	output logic                             serial_tx_tick
);
	import reload_timer_pkg::*;

	sfr_byte_t   control;
	logic [1:0]  mode_bits;
	count_t      count;
	count_t      reload;
	logic [2:0]  prescale;
	logic        clk_out;
	logic [1:0]  pin_level;
	logic [1:0]  pin_fall;
	count_mode_e mode;
	logic        baud_use;
	logic        updown_mode;
	logic        count_up;
	logic        tick;
	logic        wrap;
	logic        ext_event;
	logic [2:0]  div_now;
	logic        ctl_wr;
	sfr_byte_t   ctl_base;
	count_t      next_count;

	function automatic logic hit(input logic [7:0] ofs);
		hit = sfr_wr && (sfr_addr == ofs);
	endfunction

	pin_edge_sync #(.W(2)) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin_in  ({direction_pin, count_pin_i}),
		.level   (pin_level),
		.fall    (pin_fall)
	);

	assign baud_use = control[`CTL_RX_CLK_SEL] | control[`CTL_TX_CLK_SEL];

	// Capture is ignored while the timer clocks the serial port.
	always_comb begin
		if (control[`CTL_CAPTURE_SEL] && !baud_use)
			mode = MODE_CAPTURE;
		else if (mode_bits[`MOD_UPDOWN_EN])
			mode = MODE_UPDOWN;
		else
			mode = MODE_RELOAD;
	end

	assign updown_mode = (mode == MODE_UPDOWN);
	assign count_up    = !updown_mode || pin_level[1];

	// Baud and clock-out count at half the system clock, plain timing at a sixth.
	assign div_now = (baud_use || mode_bits[`MOD_CLKOUT_EN]) ? `DIV_FAST : `DIV_SLOW;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			prescale <= 3'h0;
		else if (!control[`CTL_RUN] || prescale >= div_now - 3'h1)
			prescale <= 3'h0;
		else
			prescale <= prescale + 3'h1;
	end

	always_comb begin
		tick = 1'b0;
		if (control[`CTL_RUN]) begin
			if (control[`CTL_SOURCE_SEL])
				tick = pin_fall[0];
			else
				tick = (prescale == div_now - 3'h1);
		end
	end

	// Up wraps past the top, down wraps when the count meets the reload value.
	assign wrap = tick && (count_up ? (count == `COUNT_TOP) : (count == reload));

	assign ext_event = control[`CTL_EXT_EDGE_EN] && pin_fall[1] && !baud_use && !updown_mode;

	always_comb begin
		next_count = count;
		if (ext_event && mode == MODE_RELOAD)
			next_count = reload;
		else if (wrap) begin
			if (!count_up)
				next_count = `COUNT_TOP;
			else if (mode == MODE_CAPTURE)
				next_count = `COUNT_ZERO;
			else
				next_count = reload;
		end else if (tick)
			next_count = count_up ? count + 16'h0001 : count - 16'h0001;
	end

	// A software write to a count byte takes precedence over counting in that cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			count <= {`RST_BYTE, `RST_BYTE};
		else begin
			count <= next_count;
			if (hit(`OFS_COUNT_LOW))
				count[7:0] <= sfr_wdata;
			if (hit(`OFS_COUNT_HIGH))
				count[15:8] <= sfr_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			reload <= {`RST_BYTE, `RST_BYTE};
		else if (ext_event && mode == MODE_CAPTURE)
			reload <= count;
		else begin
			if (hit(`OFS_RELOAD_LOW))
				reload[7:0] <= sfr_wdata;
			if (hit(`OFS_RELOAD_HIGH))
				reload[15:8] <= sfr_wdata;
		end
	end

	// Byte write or single-bit write; the flags then take hardware sets on top.
	// Written out rather than through hit(): a continuous assignment would not wake on sfr_wr read inside it.
	assign ctl_wr = (sfr_wr || sfr_bit_wr) && (sfr_addr == `OFS_CONTROL);

	always_comb begin
		ctl_base = control;
		if (hit(`OFS_CONTROL))
			ctl_base = sfr_wdata;
		else if (sfr_bit_wr && sfr_addr == `OFS_CONTROL)
			ctl_base[sfr_bit_sel] = sfr_bit_val;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			control <= `RST_CONTROL;
		else begin
			control <= ctl_wr ? ctl_base : control;
			if (wrap && !baud_use && !mode_bits[`MOD_CLKOUT_EN])
				control[`CTL_OVF_FLAG] <= 1'b1;
			if (ext_event)
				control[`CTL_EXT_FLAG] <= 1'b1;
			else if (wrap && updown_mode)
				control[`CTL_EXT_FLAG] <= ~ctl_base[`CTL_EXT_FLAG];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			mode_bits <= `RST_MODE;
		else if (hit(`OFS_MODE))
			mode_bits <= sfr_wdata[1:0];
	end

	// Each wrap flips the output, so one period spans two wraps.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			clk_out <= 1'b0;
		else if (!mode_bits[`MOD_CLKOUT_EN])
			clk_out <= 1'b0;
		else if (wrap)
			clk_out <= ~clk_out;
	end

	assign count_pin_o    = clk_out;
	assign count_pin_oe_n = ~mode_bits[`MOD_CLKOUT_EN];

	// The toggled ext flag in up/down use is a count bit, not a request.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_irq      <= 1'b0;
			serial_rx_tick <= 1'b0;
			serial_tx_tick <= 1'b0;
		end else begin
			timer_irq      <= control[`CTL_OVF_FLAG] | (control[`CTL_EXT_FLAG] & ~updown_mode);
			serial_rx_tick <= wrap & control[`CTL_RX_CLK_SEL];
			serial_tx_tick <= wrap & control[`CTL_TX_CLK_SEL];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sfr_rdata       <= `RST_BYTE;
			sfr_rdata_valid <= 1'b0;
		end else begin
			sfr_rdata_valid <= sfr_rd;
			case (sfr_addr)
				`OFS_CONTROL:     sfr_rdata <= control;
				`OFS_MODE:        sfr_rdata <= {6'h00, mode_bits};
				`OFS_RELOAD_LOW:  sfr_rdata <= reload[7:0];
				`OFS_RELOAD_HIGH: sfr_rdata <= reload[15:8];
				`OFS_COUNT_LOW:   sfr_rdata <= count[7:0];
				`OFS_COUNT_HIGH:  sfr_rdata <= count[15:8];
				default:          sfr_rdata <= `RST_BYTE;
			endcase
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_up_wrap_reload: assert property (
		(wrap && count_up && mode == MODE_RELOAD && !ext_event && !sfr_wr) |=> count == $past(reload))
		else $error("Up overflow did not load the reload value.");

	a_down_wrap_top: assert property (
		(wrap && !count_up && !sfr_wr) |=> count == 16'hFFFF)
		else $error("Underflow did not load all ones.");

	a_ovf_flag_set: assert property (
		(wrap && !baud_use && !mode_bits[`MOD_CLKOUT_EN]) |=> control[`CTL_OVF_FLAG] ##1 timer_irq)
		else $error("Overflow did not raise flag and request.");

	a_baud_no_flag: assert property (
		(wrap && baud_use && !control[`CTL_OVF_FLAG] && !ctl_wr) |=> !control[`CTL_OVF_FLAG])
		else $error("Overflow flag set while clocking the serial port.");

	a_stopped_hold: assert property (
		(!control[`CTL_RUN] && !sfr_wr && !ext_event) |=> $stable(count))
		else $error("Count moved while stopped.");

	a_clkout_toggle: assert property (
		(mode_bits[`MOD_CLKOUT_EN] && $past(mode_bits[`MOD_CLKOUT_EN]) && $past(wrap)) |-> clk_out != $past(clk_out))
		else $error("Clock output did not toggle on wrap.");

	a_updown_ext_toggle: assert property (
		(wrap && updown_mode && !ctl_wr) |=> control[`CTL_EXT_FLAG] != $past(control[`CTL_EXT_FLAG]))
		else $error("Ext flag did not toggle on up/down wrap.");

	a_edge_disabled: assert property (
		(!control[`CTL_EXT_EDGE_EN] && !control[`CTL_EXT_FLAG] && !ctl_wr && !(wrap && updown_mode))
			|=> !control[`CTL_EXT_FLAG])
		else $error("Ext flag set with edge action disabled.");

	a_rx_tick_sel: assert property (
		serial_rx_tick |-> $past(control[`CTL_RX_CLK_SEL]) && $past(wrap))
		else $error("Receive tick without selection and wrap.");

endmodule // reload_updown_timer_clockout

`default_nettype wire

// File: logic/reload_timer_cfg.svh
/*
 * Register offsets, field positions, reset values and prescale counts of the
 * reload/up-down timer with clock output.
 * Assumes it is included by bare name after the package that holds the types.
 */
`ifndef RELOAD_TIMER_CFG_SVH
`define RELOAD_TIMER_CFG_SVH

`define OFS_CONTROL       8'hC8
`define OFS_MODE          8'hC9
`define OFS_RELOAD_LOW    8'hCA
`define OFS_RELOAD_HIGH   8'hCB
`define OFS_COUNT_LOW     8'hCC
`define OFS_COUNT_HIGH    8'hCD

`define CTL_OVF_FLAG      7
`define CTL_EXT_FLAG      6
`define CTL_RX_CLK_SEL    5
`define CTL_TX_CLK_SEL    4
`define CTL_EXT_EDGE_EN   3
`define CTL_RUN           2
`define CTL_SOURCE_SEL    1
`define CTL_CAPTURE_SEL   0

`define MOD_CLKOUT_EN     1
`define MOD_UPDOWN_EN     0

`define RST_CONTROL       8'h00
`define RST_MODE          2'h0
`define RST_BYTE          8'h00

`define COUNT_TOP         16'hFFFF
`define COUNT_ZERO        16'h0000

// Internal clock divided by six in plain timer use, by two when baud or clock-out.
`define DIV_SLOW          3'h6
`define DIV_FAST          3'h2

`endif

// File: logic/reload_timer_pkg.sv
/*
 * Types shared by the reload/up-down timer files.
 * Assumes nothing of its surroundings.
 */
package reload_timer_pkg;

	typedef logic [15:0] count_t;
	typedef logic [7:0]  sfr_byte_t;

	// One-hot count mode, derived from control and mode bits.
	typedef enum logic [2:0] {
		MODE_RELOAD  = 3'b001,
		MODE_CAPTURE = 3'b010,
		MODE_UPDOWN  = 3'b100
	} count_mode_e;

endpackage

// File: logic/pin_edge_sync.sv
/*
 * Two-flop synchroniser for pin inputs, with a falling-edge pulse per bit.
 * Assumes the pins are asynchronous to clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_edge_sync #(
	parameter int W = 2
) (
	// Clock and reset.
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// Pins and results.
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] fall
);

	logic [W-1:0] stage1;
	logic [W-1:0] level_d;

	// The first stage is read by the second stage only.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stage1  <= '0;
			level   <= '0;
			level_d <= '0;
		end else begin
			stage1  <= pin_in;
			level   <= stage1;
			level_d <= level;
		end
	end

	assign fall = level_d & ~level;

endmodule // pin_edge_sync

`default_nettype wire

// File: verification/timer_pin_model.sv
/*
 * Pin-side model of the timer: an external count source and the direction level.
 * Assumes the testbench calls its tasks; the count pin has a pull-up.
 */
`timescale 1ns/1ns
`default_nettype none

module timer_pin_model (
	// Clock.
	input  wire logic clk_sys,
	// Timer side of the count pin.
	input  wire logic count_pin_o,
	input  wire logic count_pin_oe_n,
	// Pin levels seen by the timer.
	output logic      count_pin_i,
	output logic      direction_pin
);
	logic ext_level = 1'b1;
	initial direction_pin = 1'b1;
	// The pin carries the timer's clock while it drives, else our source.
	assign count_pin_i = count_pin_oe_n ? ext_level : count_pin_o;
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			#1 ext_level = 1'b0;
			repeat (4) @(posedge clk_sys);
			#1 ext_level = 1'b1;
			repeat (4) @(posedge clk_sys);
		end
	endtask
	// Levels are held four edges so that the synchroniser surely sees them.
	task automatic set_dir(input logic v);
		@(posedge clk_sys);
		#1 direction_pin = v;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule // timer_pin_model

`default_nettype wire

// File: verification/reload_updown_timer_clockout_tb.sv
/*
 * Self-checking bench of the reload/up-down timer with clock output.
 * Assumes the pin model drives the count and direction pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "reload_timer_cfg.svh"

module reload_updown_timer_clockout_tb;
	import reload_timer_pkg::*;
	logic        clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic        sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
	logic [7:0]  sfr_addr = 8'h00;
	logic [2:0]  sfr_bit_sel = 3'h0;
	sfr_byte_t   sfr_wdata = 8'h00, sfr_rdata;
	logic        sfr_rdata_valid, count_pin_i, count_pin_o, count_pin_oe_n;
	logic        direction_pin, timer_irq, rx_tick, tx_tick;
	sfr_byte_t   exp_q[$];
	int          n_fail = 0, checks = 0, cyc = 0, seed = 32'h7863, i, n;
	logic [15:0] rl;
	always #20 clk_sys = ~clk_sys;

	reload_updown_timer_clockout dut (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
		.sfr_bit_val(sfr_bit_val), .sfr_rdata_valid(sfr_rdata_valid), .sfr_rdata(sfr_rdata),
		.count_pin_i(count_pin_i), .count_pin_o(count_pin_o), .count_pin_oe_n(count_pin_oe_n),
		.direction_pin(direction_pin), .timer_irq(timer_irq), .serial_rx_tick(rx_tick), .serial_tx_tick(tx_tick));
	timer_pin_model env (.clk_sys(clk_sys), .count_pin_o(count_pin_o), .count_pin_oe_n(count_pin_oe_n),
		.count_pin_i(count_pin_i), .direction_pin(direction_pin));

	task automatic cmp_read(input sfr_byte_t got, input sfr_byte_t exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t read got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask
	task automatic cmp_cycles(input int got, input int exp, input string what);
		checks++;
		if (got != exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk_sys);
		#1 sfr_wr = 1'b0;
	endtask
	task automatic bw(input int b, input logic v);
		@(posedge clk_sys);
		#1 sfr_addr = `OFS_CONTROL;
		sfr_bit_sel = 3'(b);
		sfr_bit_val = v;
		sfr_bit_wr = 1'b1;
		@(posedge clk_sys);
		#1 sfr_bit_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		#1 sfr_addr = a;
		sfr_rd = 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys);
		#1 sfr_rd = 1'b0;
	endtask
	task automatic wait_irq(input logic v);
		for (i = 0; i < 100 && timer_irq !== v; i++) @(posedge clk_sys);
		cmp_bit(timer_irq, v, "irq");
	endtask
	// A half period is counted between two toggles, edges sampled before they update.
	task automatic half(output int h);
		logic v;
		@(posedge clk_sys);
		v = count_pin_o;
		for (h = 1; h < 300 && count_pin_o === v; h++) @(posedge clk_sys);
	endtask
	task automatic end_sim();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		if (sfr_rdata_valid === 1'b1) cmp_read(sfr_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	initial begin
		rl = 16'hFFF0 | 16'($random(seed) & 7);
		repeat (4) @(posedge clk_sys);
		#1 rst = 1'b0;
		for (n = 8'hC8; n <= 8'hCE; n++) rd(8'(n), 8'h00);
		wr(`OFS_MODE, 8'hFF);
		rd(`OFS_MODE, 8'h03);
		wr(`OFS_MODE, 8'h00);
		$display("test reset done");
		wr(`OFS_RELOAD_LOW, rl[7:0]);
		wr(`OFS_RELOAD_HIGH, 8'hFF);
		wr(`OFS_COUNT_LOW, 8'hFE);
		wr(`OFS_COUNT_HIGH, 8'hFF);
		rd(`OFS_RELOAD_LOW, rl[7:0]);
		wr(`OFS_CONTROL, 8'h04);
		wait_irq(1'b1);
		bw(`CTL_RUN, 1'b0);
		rd(`OFS_CONTROL, 8'h80);
		rd(`OFS_COUNT_HIGH, 8'hFF);
		bw(`CTL_OVF_FLAG, 1'b0);
		wait_irq(1'b0);
		$display("test overflow done");
		wr(`OFS_COUNT_LOW, 8'hFE);
		wr(`OFS_CONTROL, 8'h24);
		for (i = 0; i < 100 && rx_tick !== 1'b1; i++) @(posedge clk_sys);
		cmp_bit(rx_tick, 1'b1, "rx tick");
		cmp_bit(tx_tick, 1'b0, "tx unselected");
		bw(`CTL_TX_CLK_SEL, 1'b1);
		for (i = 0; i < 100 && tx_tick !== 1'b1; i++) @(posedge clk_sys);
		cmp_bit(tx_tick, 1'b1, "tx tick");
		bw(`CTL_RUN, 1'b0);
		rd(`OFS_CONTROL, 8'h30);
		$display("test baud done");
		wr(`OFS_MODE, 8'h02);
		wr(`OFS_CONTROL, 8'h00);
		wr(`OFS_COUNT_LOW, rl[7:0]);
		// Baud use runs beside clock-out here, so the serial tick must fall on the wrap that flips the pin.
		wr(`OFS_CONTROL, 8'h14);
		half(n);
		half(n);
		cmp_cycles(n, 2 * (32'h10000 - rl), "half period");
		cmp_bit(tx_tick, 1'b1, "shared wrap tick");
		cmp_bit(count_pin_oe_n, 1'b0, "oe");
		cmp_bit(timer_irq, 1'b0, "no irq");
		wr(`OFS_CONTROL, 8'h00);
		wr(`OFS_MODE, 8'h00);
		$display("test clock out done");
		env.set_dir(1'b0);
		rd(`OFS_CONTROL, 8'h00);
		env.set_dir(1'b1);
		wr(`OFS_CONTROL, 8'h08);
		env.set_dir(1'b0);
		rd(`OFS_CONTROL, 8'h48);
		rd(`OFS_COUNT_LOW, rl[7:0]);
		wait_irq(1'b1);
		wr(`OFS_CONTROL, 8'h00);
		$display("test edge done");
		wr(`OFS_MODE, 8'h01);
		wr(`OFS_RELOAD_LOW, 8'h00);
		wr(`OFS_RELOAD_HIGH, 8'h00);
		wr(`OFS_COUNT_LOW, 8'h02);
		wr(`OFS_COUNT_HIGH, 8'h00);
		wr(`OFS_CONTROL, 8'h04);
		wait_irq(1'b1);
		bw(`CTL_RUN, 1'b0);
		rd(`OFS_CONTROL, 8'hC0);
		rd(`OFS_COUNT_HIGH, 8'hFF);
		$display("test down count done");
		wr(`OFS_MODE, 8'h00);
		wr(`OFS_COUNT_LOW, 8'h00);
		wr(`OFS_CONTROL, 8'h06);
		env.pulse(3);
		bw(`CTL_RUN, 1'b0);
		rd(`OFS_COUNT_LOW, 8'h03);
		env.set_dir(1'b1);
		wr(`OFS_CONTROL, 8'h09);
		env.set_dir(1'b0);
		rd(`OFS_RELOAD_LOW, 8'h03);
		rd(`OFS_CONTROL, 8'h49);
		rd(`OFS_COUNT_LOW, 8'h03);
		$display("test pin count done");
		repeat (3) @(posedge clk_sys);
		end_sim();
	end
endmodule // reload_updown_timer_clockout_tb

`default_nettype wire
